// File: vpm_regs.sv
// Top of the partition map register bank: system instruction port, three
// 64-bit map registers and the virtual to physical identifier translation.
// Assumes the core presents decoded instruction fields and level controls
// synchronous to core_clk, one request at a time.
`timescale 1ns/10ps
module vpm_regs
   import vpm_pkg::*;
#(
   parameter logic VIRT_SUPPORTED = 1'b1,
   parameter int MAX_INDEX = 7
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // System instruction request
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [1:0] req_op0,
   input wire logic [2:0] req_op1,
   input wire logic [3:0] req_crn,
   input wire logic [3:0] req_crm,
   input wire logic [2:0] req_op2,
   input wire logic [63:0] req_wdata,
   // Level and control context
   input wire logic [1:0] cur_el,
   input wire logic el2_enabled,
   input wire logic nested_virt_control,
   input wire logic nested_virt_redirect,
   input wire logic have_el3,
   input wire logic lower_level_trap,
   input wire logic el1_map_enable,
   input wire logic el0_map_enable,
   input wire logic [31:0] map_entry_valid_bits,
   // System instruction answer
   output logic resp_valid,
   output logic [63:0] resp_rdata,
   output logic resp_undef,
   output logic resp_trap,
   output logic [1:0] resp_trap_el,
   output logic [5:0] resp_trap_class,
   output logic resp_redirect,
   output logic [11:0] resp_page_offset,
   // Translation request
   input wire logic xlat_valid,
   input wire logic xlat_from_el1,
   input wire logic [15:0] xlat_partition_in,
   // Translation answer
   output logic xlat_done,
   output logic xlat_mapped,
   output logic [15:0] partition_identifier,
   // Implementation features
   output logic [2:0] max_map_register_index,
   output logic virtualization_supported
);

   // -------------------------------------------------------------
   // Elaboration checks
   // -------------------------------------------------------------
   // The index field is three bits and must be zero without virtualization.
   if (MAX_INDEX < 0 || MAX_INDEX > MAX_INDEX_LIMIT)
   begin : g_bad_index
      $error("MAX_INDEX out of range");
   end
   if (!VIRT_SUPPORTED && MAX_INDEX != 0)
   begin : g_bad_virt
      $error("MAX_INDEX must be zero without virtualization");
   end

   localparam logic [2:0] MAX_IDX = 3'(MAX_INDEX);

   typedef struct packed {
      logic [GROUPS-1:0][REG_W-1:0] map;
      logic resp_valid;
      logic [63:0] resp_rdata;
      logic resp_undef;
      logic resp_trap;
      logic [1:0] resp_trap_el;
      logic [5:0] resp_trap_class;
      logic resp_redirect;
      logic [11:0] resp_page_offset;
      logic xlat_done;
      logic xlat_mapped;
      logic [15:0] xlat_partition;
      logic [2:0] max_idx;
      logic virt;
   } vpm_state_t;

   vpm_state_t r;
   vpm_state_t next_r;
   logic hit;
   logic present;
   logic [1:0] sel;
   vpm_action_t action;
   logic [1:0] trap_el;
   logic [15:0] lk_entry;
   logic [1:0] lk_group;
   logic lk_covered;
   logic lk_present;
   logic lk_enable;

   // A register of index idx exists only under virtualization and idx <= max.
   function automatic logic reg_present(input logic [2:0] idx);
      reg_present = VIRT_SUPPORTED && (idx <= MAX_IDX);
   endfunction

   // -------------------------------------------------------------
   // Decode
   // -------------------------------------------------------------
   // Encodings outside op2 1 to 3 belong to neighbouring registers and are ignored.
   assign hit = req_valid && (req_op0 == ENC_OP0) && (req_op1 == ENC_OP1) && (req_crn == ENC_CRN)
                && (req_crm == ENC_CRM) && (req_op2 >= OP2_FIRST) && (req_op2 <= OP2_LAST);
   assign present = reg_present(req_op2);
   assign sel = 2'(req_op2 - 3'h1);

   vpm_access_check u_check (
      .cur_el(cur_el),
      .present(present),
      .el2_enabled(el2_enabled),
      .nested_virt_control(nested_virt_control),
      .nested_virt_redirect(nested_virt_redirect),
      .have_el3(have_el3),
      .lower_level_trap(lower_level_trap),
      .action(action),
      .trap_el(trap_el)
   );

   vpm_map_lookup u_lookup (
      .map(r.map),
      .vid(xlat_partition_in[4:0]),
      .entry(lk_entry),
      .group_idx(lk_group),
      .covered(lk_covered)
   );

   // Only identifiers 0 to 31 can have a map entry at all.
   assign lk_present = lk_covered && (xlat_partition_in[15:5] == 11'h000)
                       && reg_present(3'({1'b0, lk_group} + 3'h1));
   assign lk_enable = xlat_from_el1 ? el1_map_enable : el0_map_enable;

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   // Answers are pulses one cycle after the request; the map itself holds.
   always_comb
   begin
      next_r = r;
      next_r.resp_valid = 1'b0;
      next_r.resp_rdata = 64'h0000000000000000;
      next_r.resp_undef = 1'b0;
      next_r.resp_trap = 1'b0;
      next_r.resp_trap_el = LVL_EL0;
      next_r.resp_trap_class = 6'h00;
      next_r.resp_redirect = 1'b0;
      next_r.resp_page_offset = 12'h000;
      next_r.max_idx = VIRT_SUPPORTED ? MAX_IDX : 3'h0;
      next_r.virt = VIRT_SUPPORTED;
      if (hit)
      begin
         next_r.resp_valid = 1'b1;
         case (action)
            ACT_DIRECT:
            begin
               if (req_write)
               begin
                  next_r.map[sel] = req_wdata;
               end
               else
               begin
                  next_r.resp_rdata = r.map[sel];
               end
            end
            ACT_TRAP:
            begin
               next_r.resp_trap = 1'b1;
               next_r.resp_trap_el = trap_el;
               next_r.resp_trap_class = TRAP_CLASS;
            end
            ACT_REDIRECT:
            begin
               // The core does the page access itself; we only name the offset.
               next_r.resp_redirect = 1'b1;
               next_r.resp_page_offset = 12'(PAGE_BASE + 12'(req_op2) * PAGE_STRIDE);
            end
            default: next_r.resp_undef = 1'b1;
         endcase
      end
      // Translation: pass-through unless every condition for a mapping holds.
      next_r.xlat_done = xlat_valid;
      next_r.xlat_mapped = 1'b0;
      next_r.xlat_partition = xlat_partition_in;
      if (xlat_valid && el2_enabled && lk_enable && lk_present
          && map_entry_valid_bits[xlat_partition_in[4:0]])
      begin
         next_r.xlat_mapped = 1'b1;
         next_r.xlat_partition = lk_entry;
      end
   end

   // -------------------------------------------------------------
   // State register
   // -------------------------------------------------------------
   // Map entries are architecturally unknown after reset; a zero constant is
   // used so nothing undefined leaks, and software must not rely on it.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r <= '0;
         r.map <= {GROUPS{MAP_RESET}};
      end
      else
      begin
         r <= next_r;
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign resp_valid = r.resp_valid;
   assign resp_rdata = r.resp_rdata;
   assign resp_undef = r.resp_undef;
   assign resp_trap = r.resp_trap;
   assign resp_trap_el = r.resp_trap_el;
   assign resp_trap_class = r.resp_trap_class;
   assign resp_redirect = r.resp_redirect;
   assign resp_page_offset = r.resp_page_offset;
   assign xlat_done = r.xlat_done;
   assign xlat_mapped = r.xlat_mapped;
   assign partition_identifier = r.xlat_partition;
   assign max_map_register_index = r.max_idx;
   assign virtualization_supported = r.virt;

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   logic tl3;
   assign tl3 = have_el3 && lower_level_trap;

   a_resp_one_cycle: assert property (hit |=> resp_valid ##1 !resp_valid || $past(hit))
      else $error("answer not a single pulse after request");
   a_el0_undefined: assert property (hit && cur_el == LVL_EL0 |=> resp_undef && !resp_trap)
      else $error("EL0 access not undefined");
   a_absent_undef: assert property (hit && !present |=> resp_undef)
      else $error("absent register access not undefined");
   a_redirect_offset: assert property (hit && present && cur_el == LVL_EL1 && el2_enabled
      && nested_virt_control && nested_virt_redirect && req_op2 == 3'h2
      |=> resp_redirect && resp_page_offset == 12'h950)
      else $error("wrong redirect offset");
   a_el1_trap_target: assert property (hit && present && cur_el == LVL_EL1 && el2_enabled
      && nested_virt_control && !nested_virt_redirect
      |=> resp_trap && resp_trap_class == 6'h18 && resp_trap_el == ($past(tl3) ? 2'h3 : 2'h2))
      else $error("EL1 trap wrong");
   a_el2_write_lands: assert property (hit && present && cur_el == LVL_EL2 && !tl3 && req_write
      |=> r.map[$past(sel)] == $past(req_wdata))
      else $error("EL2 write not stored");
   a_el3_read_back: assert property (hit && present && cur_el == LVL_EL3 && !req_write
      |=> resp_rdata == $past(r.map[sel]) && !resp_trap)
      else $error("EL3 read wrong");
   a_write_then_read: assert property (hit && present && cur_el == LVL_EL3 && req_write
      ##1 hit && present && cur_el == LVL_EL3 && !req_write && req_op2 == $past(req_op2)
      |=> resp_rdata == $past(req_wdata, 2))
      else $error("write not atomic");
   a_xlat_el2_off: assert property (xlat_valid && !el2_enabled |=> xlat_done && !xlat_mapped)
      else $error("mapped with EL2 disabled");
   a_xlat_enable: assert property (xlat_valid && !(xlat_from_el1 ? el1_map_enable : el0_map_enable)
      |=> !xlat_mapped && partition_identifier == $past(xlat_partition_in))
      else $error("mapped while disabled");
   a_xlat_valid_bit: assert property (xlat_valid && !map_entry_valid_bits[xlat_partition_in[4:0]]
      |=> !xlat_mapped)
      else $error("invalid entry used");
   a_entry_layout: assert property (xlat_valid && xlat_partition_in == 16'h000B && xlat_mapped == 1'b0
      ##1 xlat_mapped |-> partition_identifier == $past(r.map[1][63:48]))
      else $error("entry layout wrong");
   a_max_index: assert property ($past(rst_n) |-> max_map_register_index == MAX_IDX
      && virtualization_supported == VIRT_SUPPORTED
      && (virtualization_supported || max_map_register_index == 3'h0))
      else $error("max index field wrong");

   c_direct_write: cover property (hit && action == ACT_DIRECT && req_write);
   c_redirect: cover property (hit && action == ACT_REDIRECT);
   c_trap_el3: cover property (hit && action == ACT_TRAP && trap_el == LVL_EL3);
   c_xlat_mapped: cover property (xlat_mapped);

endmodule

// File: vpm_pkg.sv
// Constants shared by the partition map register bank: instruction encodings,
// field layout, redirect offsets, trap class and the access action type.
// Assumes a core that decodes system instructions into separate fields.
//
// Behaviour
// - Group two register holds physical entries for virtual identifiers 8 to 11.
// - Four 16-bit entries per register, highest identifier in bits 63 to 48.
// - Maximum-index field reports highest implemented map register, never above 7.
// - Maximum index of zero means no map register exists.
// - Translation applies per source register only when its map enable is set.
// - Entry for identifier n is used only when valid bit n is one.
// - Group two needs index above 1, group three above 2, else undefined.
// - Map registers do nothing to identifiers when EL2 is not enabled.
// - Map entries hold unknown values after reset; software programs them first.
// - Accesses decode op0 3, op1 4, CRn 10, CRm 6; op2 picks register.
// - Any access at EL0 is an undefined instruction.
// - EL1 with both nested controls redirects to page offsets 0x948, 0x950 and 0x958.
// - EL1 with nested control only traps class 0x18 to EL3 or EL2.
// - EL2 access traps to EL3 when lower trap is set, else direct.
// - EL3 reads and writes the selected register directly.
package vpm_pkg;

   // ---------------------------------------------------------------
   // Instruction encoding
   // ---------------------------------------------------------------
   localparam logic [1:0] ENC_OP0 = 2'h3;
   localparam logic [2:0] ENC_OP1 = 3'h4;
   localparam logic [3:0] ENC_CRN = 4'hA;
   localparam logic [3:0] ENC_CRM = 4'h6;
   localparam logic [2:0] OP2_FIRST = 3'h1;
   localparam logic [2:0] OP2_LAST = 3'h3;

   // ---------------------------------------------------------------
   // Field layout and reset value
   // ---------------------------------------------------------------
   localparam int ENTRY_W = 16;
   localparam int ENTRIES = 4;
   localparam int REG_W = 64;
   localparam int GROUPS = 3;
   localparam int MAX_INDEX_LIMIT = 7;
   localparam logic [63:0] MAP_RESET = 64'h0000000000000000;

   // ---------------------------------------------------------------
   // Redirect page and trap class
   // ---------------------------------------------------------------
   localparam logic [11:0] PAGE_BASE = 12'h940;
   localparam logic [11:0] PAGE_STRIDE = 12'h008;
   localparam logic [5:0] TRAP_CLASS = 6'h18;

   // Exception levels.
   localparam logic [1:0] LVL_EL0 = 2'h0;
   localparam logic [1:0] LVL_EL1 = 2'h1;
   localparam logic [1:0] LVL_EL2 = 2'h2;
   localparam logic [1:0] LVL_EL3 = 2'h3;

   typedef enum logic [1:0] {ACT_DIRECT, ACT_UNDEF, ACT_TRAP, ACT_REDIRECT} vpm_action_t;

endpackage

// File: vpm_access_check.sv
// Access check for one decoded map register instruction.
// Assumes all control inputs are stable in the cycle of the request.
`timescale 1ns/10ps
module vpm_access_check
   import vpm_pkg::*;
(
   // Context of the access
   input wire logic [1:0] cur_el,
   input wire logic present,
   input wire logic el2_enabled,
   input wire logic nested_virt_control,
   input wire logic nested_virt_redirect,
   input wire logic have_el3,
   input wire logic lower_level_trap,
   // Decision
   output vpm_action_t action,
   output logic [1:0] trap_el
);

   // -------------------------------------------------------------
   // Decision tree
   // -------------------------------------------------------------
   // An absent register is undefined at every level, so presence is checked first.
   always_comb
   begin
      action = ACT_UNDEF;
      trap_el = LVL_EL2;
      if (!present)
      begin
         action = ACT_UNDEF;
      end
      else
      begin
         case (cur_el)
            LVL_EL0: action = ACT_UNDEF;
            LVL_EL1:
            begin
               if (el2_enabled && nested_virt_redirect && nested_virt_control)
               begin
                  action = ACT_REDIRECT;
               end
               else if (el2_enabled && nested_virt_control)
               begin
                  action = ACT_TRAP;
                  trap_el = (have_el3 && lower_level_trap) ? LVL_EL3 : LVL_EL2;
               end
               else
               begin
                  action = ACT_UNDEF;
               end
            end
            LVL_EL2:
            begin
               if (have_el3 && lower_level_trap)
               begin
                  action = ACT_TRAP;
                  trap_el = LVL_EL3;
               end
               else
               begin
                  action = ACT_DIRECT;
               end
            end
            default: action = ACT_DIRECT;
         endcase
      end
   end

endmodule

// File: vpm_map_lookup.sv
// Selects the 16-bit map entry for a virtual identifier from the held groups.
// Assumes group index 0 of the array is the register for identifiers 4 to 7.
`timescale 1ns/10ps
module vpm_map_lookup
   import vpm_pkg::*;
(
   // Held map registers
   input wire logic [GROUPS-1:0][REG_W-1:0] map,
   // Query
   input wire logic [4:0] vid,
   output logic [ENTRY_W-1:0] entry,
   output logic [1:0] group_idx,
   output logic covered
);

   // Slot 0 sits in bits 15 to 0, slot 3 in bits 63 to 48.
   function automatic logic [ENTRY_W-1:0] entry_of(input logic [REG_W-1:0] word, input logic [1:0] slot);
      entry_of = word[slot*ENTRY_W +: ENTRY_W];
   endfunction

   // -------------------------------------------------------------
   // Entry select
   // -------------------------------------------------------------
   // Only identifiers 4 to 15 live here; others belong to registers elsewhere.
   always_comb
   begin
      covered = (vid[4:2] >= OP2_FIRST) && (vid[4:2] <= OP2_LAST);
      group_idx = 2'(vid[4:2] - 3'h1);
      entry = covered ? entry_of(map[group_idx], vid[1:0]) : {11'h000, vid};
   end

endmodule

// File: tb_vpm_regs.sv
// Self-checking testbench for the partition map register bank top, vpm_regs.
// Assumes the default parameters (virtualization present, maximum index 7) for
// i_dut, a maximum index of 1 for a second bank, and drives every input at the
// falling edge of core_clk.
`timescale 1ns/10ps
module tb_vpm_regs;
   import vpm_pkg::*;

   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic [1:0] req_op0 = ENC_OP0;
   logic [2:0] req_op1 = ENC_OP1;
   logic [3:0] req_crn = ENC_CRN;
   logic [3:0] req_crm = ENC_CRM;
   logic [2:0] req_op2 = 3'h1;
   logic [63:0] req_wdata = 64'h0;
   logic [1:0] cur_el = 2'h3;
   logic el2_enabled = 1'b1;
   logic nested_virt_control = 1'b0;
   logic nested_virt_redirect = 1'b0;
   logic have_el3 = 1'b1;
   logic lower_level_trap = 1'b0;
   logic el1_map_enable = 1'b0;
   logic el0_map_enable = 1'b0;
   logic [31:0] map_entry_valid_bits = 32'h0;
   logic xlat_valid = 1'b0;
   logic xlat_from_el1 = 1'b0;
   logic [15:0] xlat_partition_in = 16'h0;
   logic resp_valid, resp_undef, resp_trap, resp_redirect;
   logic [63:0] resp_rdata;
   logic [1:0] resp_trap_el;
   logic [5:0] resp_trap_class;
   logic [11:0] resp_page_offset;
   logic xlat_done, xlat_mapped, virtualization_supported;
   logic [15:0] partition_identifier;
   logic [2:0] max_map_register_index;
   logic [63:0] mdl [1:3];
   int err_count = 0;
   int n_tests = 0;
   int cycles = 0;
   integer seed = 16;
   logic [31:0] r;
   logic b_valid, b_undef, b_mapped;
   logic [2:0] b_max;

   vpm_regs i_dut (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
      .req_op0(req_op0), .req_op1(req_op1), .req_crn(req_crn), .req_crm(req_crm), .req_op2(req_op2),
      .req_wdata(req_wdata), .cur_el(cur_el), .el2_enabled(el2_enabled),
      .nested_virt_control(nested_virt_control), .nested_virt_redirect(nested_virt_redirect),
      .have_el3(have_el3), .lower_level_trap(lower_level_trap), .el1_map_enable(el1_map_enable),
      .el0_map_enable(el0_map_enable), .map_entry_valid_bits(map_entry_valid_bits),
      .resp_valid(resp_valid), .resp_rdata(resp_rdata), .resp_undef(resp_undef), .resp_trap(resp_trap),
      .resp_trap_el(resp_trap_el), .resp_trap_class(resp_trap_class), .resp_redirect(resp_redirect),
      .resp_page_offset(resp_page_offset), .xlat_valid(xlat_valid), .xlat_from_el1(xlat_from_el1),
      .xlat_partition_in(xlat_partition_in), .xlat_done(xlat_done), .xlat_mapped(xlat_mapped),
      .partition_identifier(partition_identifier), .max_map_register_index(max_map_register_index),
      .virtualization_supported(virtualization_supported));

   // A second bank with only the first map register, so that absent registers are reached.
   vpm_regs #(.MAX_INDEX(1)) i_dut_small (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid),
      .req_write(req_write), .req_op0(req_op0), .req_op1(req_op1), .req_crn(req_crn), .req_crm(req_crm),
      .req_op2(req_op2), .req_wdata(req_wdata), .cur_el(cur_el), .el2_enabled(el2_enabled),
      .nested_virt_control(nested_virt_control), .nested_virt_redirect(nested_virt_redirect),
      .have_el3(have_el3), .lower_level_trap(lower_level_trap), .el1_map_enable(el1_map_enable),
      .el0_map_enable(el0_map_enable), .map_entry_valid_bits(map_entry_valid_bits),
      .resp_valid(b_valid), .resp_rdata(), .resp_undef(b_undef), .resp_trap(), .resp_trap_el(),
      .resp_trap_class(), .resp_redirect(), .resp_page_offset(), .xlat_valid(xlat_valid),
      .xlat_from_el1(xlat_from_el1), .xlat_partition_in(xlat_partition_in), .xlat_done(),
      .xlat_mapped(b_mapped), .partition_identifier(), .max_map_register_index(b_max),
      .virtualization_supported());

   // Free running 100 MHz clock.
   always #5 core_clk = ~core_clk;

   // ---------------------------------------------------------------
   // Expectation functions and shared tasks
   // ---------------------------------------------------------------
   // Expected answer as {undef, trap, trap level, redirect}; all zero means direct.
   function automatic logic [4:0] exp_resp(input logic [1:0] el, input logic e2, nv, nv2, h3, tl);
      if (el == 2'h0)
         return 5'h10;
      if (el == 2'h1)
      begin
         if (e2 && nv && nv2)
            return 5'h01;
         if (e2 && nv)
            return {2'b01, (h3 && tl) ? 2'h3 : 2'h2, 1'b0};
         return 5'h10;
      end
      if (el == 2'h2 && h3 && tl)
         return 5'h0E;
      return 5'h00;
   endfunction

   // Expected translation as {mapped, identifier}; unmapped identifiers pass through.
   function automatic logic [16:0] exp_xlat(input logic f1, input logic [15:0] id);
      logic hit;
      hit = el2_enabled && (f1 ? el1_map_enable : el0_map_enable) && id >= 16'h0004 && id <= 16'h000F
         && map_entry_valid_bits[id[4:0]];
      return hit ? {1'b1, mdl[id[3:2]][16*id[1:0] +: 16]} : {1'b0, id};
   endfunction

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   // One register access; the strobe stays high so that calls can follow back to back.
   task automatic do_req(input logic w, input logic [2:0] op2, input logic [63:0] wd);
      logic [4:0] ex;
      ex = exp_resp(cur_el, el2_enabled, nested_virt_control, nested_virt_redirect, have_el3, lower_level_trap);
      req_valid = 1'b1;
      req_write = w;
      req_op2 = op2;
      req_wdata = wd;
      @(negedge core_clk);
      check("resp_valid", resp_valid, 64'h1);
      check("resp_undef", resp_undef, ex[4]);
      check("small resp_valid", b_valid, 64'h1);
      check("small resp_undef", b_undef, ex[4] | (op2 > 3'h1));
      check("resp_trap", resp_trap, ex[3]);
      check("resp_redirect", resp_redirect, ex[0]);
      if (ex[3])
      begin
         check("resp_trap_el", resp_trap_el, ex[2:1]);
         check("resp_trap_class", resp_trap_class, 6'h18);
      end
      if (ex[0])
         check("resp_page_offset", resp_page_offset, 12'h940 + {6'h0, op2, 3'h0});
      check("resp_rdata", resp_rdata, (ex == 5'h00 && !w) ? mdl[op2] : 64'h0);
      if (ex == 5'h00 && w)
         mdl[op2] = wd;
   endtask

   // One translation, also held high for back to back use.
   task automatic do_xlat(input logic f1, input logic [15:0] id);
      logic [16:0] ex;
      ex = exp_xlat(f1, id);
      xlat_valid = 1'b1;
      xlat_from_el1 = f1;
      xlat_partition_in = id;
      @(negedge core_clk);
      check("xlat_done", xlat_done, 64'h1);
      check("xlat_mapped", xlat_mapped, ex[16]);
      check("small xlat_mapped", b_mapped, ex[16] & (id[3:2] == 2'h1));
      check("partition_identifier", partition_identifier, ex[15:0]);
   endtask

   task automatic idle();
      req_valid = 1'b0;
      xlat_valid = 1'b0;
      @(negedge core_clk);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // A hang counts as a mismatch; the whole run needs well under a thousand cycles.
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         report_and_stop();
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (3) @(negedge core_clk);
      rst_n = 1'b1;
      @(negedge core_clk);
      check("max_map_register_index", max_map_register_index, 64'h7);
      check("virtualization_supported", virtualization_supported, 64'h1);
      check("small max_map_register_index", b_max, 64'h1);
      $display("test features done");

      // Fill all three groups at EL3, then a read right after a write sees it.
      for (int g = 1; g <= 3; g++)
         do_req(1'b1, g[2:0], {$random(seed), $random(seed)});
      do_req(1'b0, 3'h2, 64'h0);
      do_req(1'b1, 3'h2, 64'hFFFF0000_8000FFFF);
      do_req(1'b0, 3'h2, 64'h0);
      for (int g = 1; g <= 3; g++)
         do_req(1'b0, g[2:0], 64'h0);
      idle();
      $display("test direct access done");

      // Encodings outside this bank are ignored.
      req_crm = 4'h7;
      req_valid = 1'b1;
      @(negedge core_clk);
      check("resp_valid", resp_valid, 64'h0);
      req_crm = ENC_CRM;
      req_op2 = 3'h0;
      @(negedge core_clk);
      check("resp_valid", resp_valid, 64'h0);
      idle();
      $display("test foreign encoding done");

      // Every level and control combination, with random reads and writes back to back.
      for (int i = 0; i < 128; i++)
      begin
         {cur_el, el2_enabled, nested_virt_control, nested_virt_redirect, have_el3, lower_level_trap} = i[6:0];
         r = $random(seed);
         do_req(r[0], (r[2:1] == 2'h3) ? 3'h3 : {1'b0, r[2:1]} + 3'h1, {$random(seed), r});
      end
      {cur_el, el2_enabled, nested_virt_control, nested_virt_redirect, have_el3, lower_level_trap} = 7'h52;
      for (int g = 1; g <= 3; g++)
         do_req(1'b0, g[2:0], 64'h0);
      idle();
      $display("test level table done");

      // Translation: the hand case for identifier 9 first, then random traffic every cycle.
      el2_enabled = 1'b1;
      el1_map_enable = 1'b1;
      map_entry_valid_bits = 32'h0000_0200;
      do_xlat(1'b1, 16'h0009);
      el2_enabled = 1'b0;
      do_xlat(1'b1, 16'h0009);
      for (int i = 0; i < 300; i++)
      begin
         r = $random(seed);
         el2_enabled = r[0] | r[1];
         el1_map_enable = r[2] | r[12];
         el0_map_enable = r[3] | r[13];
         map_entry_valid_bits = $random(seed);
         do_xlat(r[4], r[5] ? {11'h0, r[10:6]} : {7'h0, r[11], 4'h0, r[9:6]});
      end
      idle();
      $display("test translation done");
      report_and_stop();
   end
endmodule
